// *** coid_pkg.sv ***
// constants shared by the instruction decoder files
// Operation
// - clear blanks display memory, pointer zero, 6.2ms
// - return home zeroes pointer and display shift
// - entry mode stores step direction, follow shift
// - display control latches display, cursor, blink
// - shift moves cursor or display, memory untouched
// - mode variant latches graphic select and power
// - function set latches width, lines, glyph, font
// - glyph address load targets glyph memory
// - display address load targets display memory
// - status read returns pending flag and pointer
// - data write stores at pointer, selected memory
// - data read returns byte at pointer
// - 8080 port with separate low strobes
// - 6800 port with enable and direction
// - serial port framed by select, DB5 clock
// - while pending only status read is honoured
// - pointer steps by one after data access
package coid_pkg;
    localparam int CLK_FREQ_MHZ = 125;
    localparam int CLEAR_TIME_US = 6200;
    localparam int CLEAR_CYC = CLEAR_TIME_US * CLK_FREQ_MHZ;
    localparam int DD_DEPTH = 128;
    localparam int CG_DEPTH = 64;
    localparam int FIFO_DEPTH = 4;
    localparam int WORD_W = 10;
    localparam int PIN_N = 12;
    localparam logic [7:0] BLANK_CHAR = 8'h20;
    localparam logic [1:0] MODE_8080 = 2'h0;
    localparam logic [1:0] MODE_6800 = 2'h1;
    localparam logic [1:0] MODE_SERIAL = 2'h2;
    localparam logic [7:0] OP_CLEAR = 8'h01;
    localparam logic [6:0] OP_HOME = 7'h01;
    localparam logic [5:0] OP_ENTRY = 6'h01;
    localparam logic [4:0] OP_DISP = 5'h01;
    localparam logic [3:0] OP_SHIFT = 4'h1;
    localparam logic [1:0] SUB_SHIFT = 2'h0;
    localparam logic [1:0] SUB_MODE = 2'h3;
    localparam logic [2:0] OP_FUNC = 3'h1;
    localparam logic [1:0] OP_CGADDR = 2'h1;
    localparam int B_TOP = 7;
    localparam int B_SEL = 3;
    localparam int B_DIR = 2;
    localparam int B_WIDTH = 4;
    localparam int B_ID = 1;
    localparam int B_S = 0;
    localparam int W_RS = 9;
    localparam int W_RW = 8;
    localparam int SER_SCLK = 5;
    localparam int SER_SDO = 6;
    localparam int SER_SDI = 7;
    localparam logic [3:0] SER_LAST = 4'h9;
    localparam logic [3:0] SER_RW_BIT = 4'h1;
    localparam logic [3:0] SER_SHIFT_FROM = 4'h3;
    localparam logic [2:0] ARM_DONE = 3'h5;
    localparam logic RST_BUS8 = 1'b1;
    localparam logic RST_DIR = 1'b1;
    localparam logic [PIN_N-1:0] PIN_RST = 12'h000;
endpackage

// *** coid_stream_if.sv ***
// valid/ready word carrier between decoder and buffer
`timescale 1ns/1ns
`default_nettype none
interface coid_stream_if #(parameter int WIDTH = 10);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport tx (output valid, output data, input ready);
    modport rx (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** coid_fifo.sv ***
// small flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module coid_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    coid_stream_if.rx s_in,
    coid_stream_if.tx s_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign s_in.ready = cnt_reg != (AW+1)'(DEPTH);
    assign s_out.valid = cnt_reg != '0;
    assign s_out.data = mem_reg[rd_reg];
    assign push = s_in.valid & s_in.ready;
    assign pop = s_out.valid & s_out.ready;

    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem_reg[wr_reg] <= s_in.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else if (i_ce) begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// *** coid_decoder.sv ***
// host port and instruction executor of the character display controller
`timescale 1ns/1ns
`default_nettype none
module coid_decoder #(
    parameter int CLEAR_CYCLES = coid_pkg::CLEAR_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [1:0] i_port_mode,
    input wire logic i_cmd_data_select,
    input wire logic i_rw_write_strobe,
    input wire logic i_enable_read_strobe,
    input wire logic i_serial_select_n,
    input wire logic [7:0] i_db,
    output logic [7:0] o_db,
    output logic [7:0] o_db_oe,
    output logic o_operation_pending_flag,
    output logic [6:0] o_address_pointer,
    output logic o_glyph_target,
    output logic [6:0] o_display_shift,
    output logic o_step_direction,
    output logic o_display_follow_shift,
    output logic o_display_on,
    output logic o_cursor_on,
    output logic o_cursor_blink,
    output logic o_graphic_char_select,
    output logic o_internal_power_on,
    output logic o_bus_width_select,
    output logic o_line_count_select,
    output logic o_glyph_size_select,
    output logic [1:0] o_font_table_select
);
    typedef enum logic {EX_IDLE = 1'b0, EX_CLEAR = 1'b1} coid_ex_t;

    coid_stream_if #(.WIDTH(coid_pkg::WORD_W)) push_if ();
    coid_stream_if #(.WIDTH(coid_pkg::WORD_W)) pop_if ();

    coid_fifo #(.WIDTH(coid_pkg::WORD_W), .DEPTH(coid_pkg::FIFO_DEPTH)) u_fifo (
        .i_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .s_in(push_if),
        .s_out(pop_if)
    );

    logic [coid_pkg::PIN_N-1:0] pin_raw;
    logic [coid_pkg::PIN_N-1:0] pin_f;
    logic [2:0] arm_reg;
    logic armed;
    logic f_rs;
    logic f_wr;
    logic f_erd;
    logic f_csb;
    logic [7:0] f_db;
    logic m80;
    logic m68;
    logic mser;
    logic wr_act;
    logic rd_act;
    logic wr_q_reg;
    logic rd_q_reg;
    logic wr_end;
    logic rd_start;
    logic rd_end;
    logic narrow;
    logic half_reg;
    logic [3:0] hi_nib_reg;
    logic [7:0] rd_byte_reg;
    logic [7:0] db_out_reg;
    logic [7:0] oe_reg;
    logic rd_rs_reg;
    logic rd_ok_reg;
    logic ser_sel;
    logic sclk_q_reg;
    logic s_rise;
    logic s_fall;
    logic [3:0] bit_reg;
    logic [8:0] sin_reg;
    logic [7:0] sout_reg;
    logic ser_rw_reg;
    logic busy;
    coid_ex_t state_reg;
    logic [19:0] cnt_reg;
    logic [6:0] ptr_reg;
    logic glyph_reg;
    logic [6:0] shift_reg;
    logic dir_reg;
    logic follow_reg;
    logic [7:0] display_ram_reg [coid_pkg::DD_DEPTH];
    logic [7:0] glyph_ram_reg [coid_pkg::CG_DEPTH];
    logic pop;
    logic [7:0] b;
    logic is_cmd;
    logic do_clear;
    logic do_home;
    logic do_entry;
    logic do_disp;
    logic do_shift;
    logic do_mode;
    logic do_func;
    logic do_cg;
    logic do_dd;
    logic do_dwr;
    logic do_step;
    logic move_dir;
    logic [6:0] ptr_moved;

    function automatic logic [7:0] rd_src(input logic rs);
        if (!rs) begin
            return {busy, ptr_reg};
        end
        return glyph_reg ? glyph_ram_reg[ptr_reg[5:0]] : display_ram_reg[ptr_reg];
    endfunction

    // pin synchronisers, change taken when stages two and three agree
    assign pin_raw = {i_cmd_data_select, i_rw_write_strobe, i_enable_read_strobe,
                      i_serial_select_n, i_db};
    for (genvar g = 0; g < coid_pkg::PIN_N; g++) begin : g_sync
        logic [2:0] sh_reg;
        logic filt_reg;
        always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
                sh_reg <= 3'h0;
                filt_reg <= coid_pkg::PIN_RST[g];
            end else if (i_ce) begin
                sh_reg <= {sh_reg[1:0], pin_raw[g]};
                if (sh_reg[1] == sh_reg[2]) begin
                    filt_reg <= sh_reg[2];
                end
            end
        end
        assign pin_f[g] = filt_reg;
    end
    assign {f_rs, f_wr, f_erd, f_csb, f_db} = pin_f;

    // edges are ignored until the filters have settled after reset
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            arm_reg <= 3'h0;
        end else if (i_ce && !armed) begin
            arm_reg <= arm_reg + 3'h1;
        end
    end
    assign armed = arm_reg == coid_pkg::ARM_DONE;

    assign m80 = i_port_mode == coid_pkg::MODE_8080;
    assign m68 = i_port_mode == coid_pkg::MODE_6800;
    assign mser = i_port_mode == coid_pkg::MODE_SERIAL;
    assign wr_act = (m80 & ~f_wr) | (m68 & f_erd & ~f_wr);
    assign rd_act = (m80 & ~f_erd) | (m68 & f_erd & f_wr);
    assign wr_end = armed & wr_q_reg & ~wr_act;
    assign rd_start = armed & rd_act & ~rd_q_reg;
    assign rd_end = armed & rd_q_reg & ~rd_act;
    assign narrow = ~o_bus_width_select;
    assign busy = (state_reg != EX_IDLE) | pop_if.valid;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wr_q_reg <= 1'b0;
            rd_q_reg <= 1'b0;
            sclk_q_reg <= 1'b0;
        end else if (i_ce) begin
            wr_q_reg <= wr_act;
            rd_q_reg <= rd_act;
            sclk_q_reg <= f_db[coid_pkg::SER_SCLK];
        end
    end

    // parallel nibble pairing and read latch
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            half_reg <= 1'b0;
            hi_nib_reg <= 4'h0;
            rd_byte_reg <= 8'h00;
            db_out_reg <= 8'h00;
            rd_rs_reg <= 1'b0;
            rd_ok_reg <= 1'b0;
        end else if (i_ce) begin
            if (wr_end) begin
                if (narrow && !half_reg) begin
                    hi_nib_reg <= f_db[7:4];
                end
                half_reg <= narrow & ~half_reg;
            end else if (rd_end) begin
                half_reg <= narrow & ~half_reg;
            end
            if (rd_start && (!narrow || !half_reg)) begin
                rd_byte_reg <= rd_src(f_rs);
                db_out_reg <= narrow ? {rd_src(f_rs) >> 4} << 4 : rd_src(f_rs);
                rd_rs_reg <= f_rs;
                rd_ok_reg <= ~busy;
            end else if (rd_start) begin
                db_out_reg <= {rd_byte_reg[3:0], 4'h0};
            end
        end
    end

    // serial framing: rs, rw, then eight bits msb first
    assign ser_sel = mser & ~f_csb;
    assign s_rise = armed & ser_sel & f_db[coid_pkg::SER_SCLK] & ~sclk_q_reg;
    assign s_fall = armed & ser_sel & ~f_db[coid_pkg::SER_SCLK] & sclk_q_reg;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            bit_reg <= 4'h0;
            sin_reg <= 9'h000;
            sout_reg <= 8'h00;
            ser_rw_reg <= 1'b0;
        end else if (i_ce) begin
            if (!ser_sel) begin
                bit_reg <= 4'h0;
                ser_rw_reg <= 1'b0;
            end else if (s_rise) begin
                sin_reg <= {sin_reg[7:0], f_db[coid_pkg::SER_SDI]};
                bit_reg <= (bit_reg == coid_pkg::SER_LAST) ? 4'h0 : bit_reg + 4'h1;
                if (bit_reg == coid_pkg::SER_RW_BIT) begin
                    ser_rw_reg <= f_db[coid_pkg::SER_SDI];
                    sout_reg <= rd_src(sin_reg[0]);
                end
            end else if (s_fall && bit_reg >= coid_pkg::SER_SHIFT_FROM) begin
                sout_reg <= {sout_reg[6:0], 1'b0};
            end
        end
    end

    always_comb begin
        push_if.valid = 1'b0;
        push_if.data = '0;
        if (wr_end && !(narrow && !half_reg) && !busy) begin
            push_if.valid = 1'b1;
            push_if.data = {f_rs, 1'b0, narrow ? {hi_nib_reg, f_db[7:4]} : f_db};
        end else if (rd_end && rd_rs_reg && rd_ok_reg && !(narrow && !half_reg)) begin
            push_if.valid = 1'b1;
            push_if.data = {2'b11, 8'h00};
        end else if (s_rise && bit_reg == coid_pkg::SER_LAST && !busy) begin
            push_if.valid = ~ser_rw_reg | sin_reg[8];
            push_if.data = {sin_reg[8], ser_rw_reg, sin_reg[6:0], f_db[coid_pkg::SER_SDI]};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            oe_reg <= 8'h00;
        end else if (i_ce) begin
            if (rd_act && armed) begin
                oe_reg <= narrow ? 8'hF0 : 8'hFF;
            end else if (ser_sel && ser_rw_reg) begin
                oe_reg <= 8'h40;
            end else begin
                oe_reg <= 8'h00;
            end
        end
    end
    assign o_db = mser ? {1'b0, sout_reg[7], 6'h00} : db_out_reg;
    assign o_db_oe = oe_reg;

    // instruction decode
    assign pop = pop_if.valid & (state_reg == EX_IDLE);
    assign pop_if.ready = state_reg == EX_IDLE;
    assign b = pop_if.data[7:0];
    assign is_cmd = pop & ~pop_if.data[coid_pkg::W_RS] & ~pop_if.data[coid_pkg::W_RW];
    assign do_clear = is_cmd & (b == coid_pkg::OP_CLEAR);
    assign do_home = is_cmd & (b[7:1] == coid_pkg::OP_HOME);
    assign do_entry = is_cmd & (b[7:2] == coid_pkg::OP_ENTRY);
    assign do_disp = is_cmd & (b[7:3] == coid_pkg::OP_DISP);
    assign do_shift = is_cmd & (b[7:4] == coid_pkg::OP_SHIFT) & (b[1:0] == coid_pkg::SUB_SHIFT);
    assign do_mode = is_cmd & (b[7:4] == coid_pkg::OP_SHIFT) & (b[1:0] == coid_pkg::SUB_MODE);
    assign do_func = is_cmd & (b[7:5] == coid_pkg::OP_FUNC);
    assign do_cg = is_cmd & (b[7:6] == coid_pkg::OP_CGADDR);
    assign do_dd = is_cmd & b[coid_pkg::B_TOP];
    assign do_dwr = pop & pop_if.data[coid_pkg::W_RS] & ~pop_if.data[coid_pkg::W_RW];
    assign do_step = pop & pop_if.data[coid_pkg::W_RS];
    assign move_dir = do_step ? dir_reg : b[coid_pkg::B_DIR];
    always_comb begin
        ptr_moved = move_dir ? ptr_reg + 7'h01 : ptr_reg - 7'h01;
        if (glyph_reg) begin
            ptr_moved[6] = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_reg <= EX_IDLE;
            cnt_reg <= 20'h0_0000;
        end else if (i_ce) begin
            unique case (state_reg)
                EX_IDLE: begin
                    cnt_reg <= 20'h0_0000;
                    if (do_clear) begin
                        state_reg <= EX_CLEAR;
                    end
                end
                EX_CLEAR: begin
                    cnt_reg <= cnt_reg + 20'h0_0001;
                    if (cnt_reg == 20'(CLEAR_CYCLES - 1)) begin
                        state_reg <= EX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_ce && state_reg == EX_CLEAR && cnt_reg < 20'(coid_pkg::DD_DEPTH)) begin
            display_ram_reg[cnt_reg[6:0]] <= coid_pkg::BLANK_CHAR;
        end else if (i_ce && do_dwr && !glyph_reg) begin
            display_ram_reg[ptr_reg] <= b;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_ce && do_dwr && glyph_reg) begin
            glyph_ram_reg[ptr_reg[5:0]] <= b;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ptr_reg <= 7'h00;
            glyph_reg <= 1'b0;
        end else if (i_ce) begin
            if (do_clear || do_home) begin
                ptr_reg <= 7'h00;
                glyph_reg <= 1'b0;
            end else if (do_cg) begin
                ptr_reg <= {1'b0, b[5:0]};
                glyph_reg <= 1'b1;
            end else if (do_dd) begin
                ptr_reg <= b[6:0];
                glyph_reg <= 1'b0;
            end else if (do_step || (do_shift && !b[coid_pkg::B_SEL])) begin
                ptr_reg <= ptr_moved;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            shift_reg <= 7'h00;
        end else if (i_ce) begin
            if (do_clear || do_home) begin
                shift_reg <= 7'h00;
            end else if ((do_shift && b[coid_pkg::B_SEL]) || (do_step && follow_reg)) begin
                shift_reg <= move_dir ? shift_reg + 7'h01 : shift_reg - 7'h01;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            dir_reg <= coid_pkg::RST_DIR;
            follow_reg <= 1'b0;
            {o_display_on, o_cursor_on, o_cursor_blink} <= 3'h0;
            {o_graphic_char_select, o_internal_power_on} <= 2'h0;
            o_bus_width_select <= coid_pkg::RST_BUS8;
            {o_line_count_select, o_glyph_size_select, o_font_table_select} <= 4'h0;
        end else if (i_ce) begin
            if (do_entry) begin
                dir_reg <= b[coid_pkg::B_ID];
                follow_reg <= b[coid_pkg::B_S];
            end
            if (do_disp) begin
                {o_display_on, o_cursor_on, o_cursor_blink} <= b[2:0];
            end
            if (do_mode) begin
                {o_graphic_char_select, o_internal_power_on} <= b[3:2];
            end
            if (do_func) begin
                o_bus_width_select <= b[coid_pkg::B_WIDTH];
                {o_line_count_select, o_glyph_size_select, o_font_table_select} <= b[3:0];
            end
        end
    end

    assign o_operation_pending_flag = busy;
    assign o_address_pointer = ptr_reg;
    assign o_glyph_target = glyph_reg;
    assign o_display_shift = shift_reg;
    assign o_step_direction = dir_reg;
    assign o_display_follow_shift = follow_reg;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst || !i_ce);

    sequence s_clear_start;
        do_clear ##1 state_reg == EX_CLEAR;
    endsequence
    property p_clear;
        s_clear_start |-> ptr_reg == 7'h00 && busy;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not start");
    property p_clear_len;
        state_reg == EX_CLEAR |-> cnt_reg <= 20'(CLEAR_CYCLES - 1) && busy;
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear overran");
    property p_home;
        do_home |=> ptr_reg == 7'h00 && shift_reg == 7'h00 && !glyph_reg;
    endproperty
    a_home: assert property (p_home) else $error("home failed");
    property p_entry;
        do_entry |=> dir_reg == $past(b[1]) && follow_reg == $past(b[0]);
    endproperty
    a_entry: assert property (p_entry) else $error("entry mode not latched");
    property p_disp;
        do_disp |=> {o_display_on, o_cursor_on, o_cursor_blink} == $past(b[2:0]);
    endproperty
    a_disp: assert property (p_disp) else $error("display control wrong");
    property p_shift_cursor;
        do_shift && !b[3] && !glyph_reg && b[2] |=> ptr_reg == $past(ptr_reg) + 7'h01;
    endproperty
    a_shift_cursor: assert property (p_shift_cursor) else $error("cursor move wrong");
    property p_mode;
        do_mode |=> o_graphic_char_select == $past(b[3]) && o_internal_power_on == $past(b[2]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not latched");
    property p_func;
        do_func |=> o_bus_width_select == $past(b[4]) && o_font_table_select == $past(b[1:0]);
    endproperty
    a_func: assert property (p_func) else $error("function set wrong");
    property p_cg;
        do_cg |=> glyph_reg && ptr_reg == {1'b0, $past(b[5:0])};
    endproperty
    a_cg: assert property (p_cg) else $error("glyph address wrong");
    property p_dd;
        do_dd |=> !glyph_reg && ptr_reg == $past(b[6:0]);
    endproperty
    a_dd: assert property (p_dd) else $error("display address wrong");
    property p_write;
        do_dwr && !glyph_reg |=> display_ram_reg[$past(ptr_reg)] == $past(b);
    endproperty
    a_write: assert property (p_write) else $error("data not stored");
    property p_step;
        do_step && dir_reg && !glyph_reg |=> ptr_reg == $past(ptr_reg) + 7'h01;
    endproperty
    a_step: assert property (p_step) else $error("pointer did not step");
    property p_pending;
        wr_end && o_operation_pending_flag |-> !push_if.valid;
    endproperty
    a_pending: assert property (p_pending) else $error("write taken while pending");
endmodule
`default_nettype wire

// *** coid_host.sv ***
// host model driving the parallel strobes and serial frames
`timescale 1ns/1ns
`default_nettype none
module coid_host (
    input wire logic i_clk,
    input wire logic [7:0] i_dbus,
    input wire logic i_m68,
    output logic o_rs,
    output logic o_wr_n,
    output logic o_rd_n,
    output logic [7:0] o_db,
    output logic o_csb_n
);
    initial begin
        o_rs = 1'b0;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_db = 8'h00;
        o_csb_n = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // strobe held past the pin filters
    task automatic wr(input logic rs, input logic [7:0] b);
        o_rs <= rs;
        o_db <= b;
        o_wr_n <= 1'b0;
        o_rd_n <= 1'b1;
        cyc(12);
        o_wr_n <= !i_m68;
        o_rd_n <= !i_m68;
        cyc(10);
    endtask
    task automatic rd(input logic rs, output logic [7:0] b);
        o_rs <= rs;
        o_db <= ~o_db;
        o_wr_n <= 1'b1;
        o_rd_n <= i_m68;
        cyc(12);
        b = i_dbus;
        o_rd_n <= !i_m68;
        cyc(10);
    endtask
    // idle strobe levels of the selected parallel style
    task automatic park();
        o_wr_n <= 1'b1;
        o_rd_n <= !i_m68;
    endtask
    // frame: select low, ten clock pulses, sdo sampled late in each high phase
    task automatic ser(input logic [9:0] f, output logic [7:0] b);
        o_csb_n <= 1'b0;
        for (int i = 9; i >= 0; i--) begin
            o_db <= {f[i], 7'h00};
            cyc(10);
            o_db <= {f[i], 7'h20};
            cyc(10);
            b = {b[6:0], i_dbus[6]};
        end
        o_csb_n <= 1'b1;
        cyc(10);
    endtask
    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 400; i++) begin
            rd(1'b0, s);
            if (s[7] === 1'b0) break;
        end
    endtask
endmodule
`default_nettype wire

// *** char_oled_instruction_decoder_test.sv ***
// self-checking bench for the instruction decoder
`timescale 1ns/1ns
`default_nettype none
module char_oled_instruction_decoder_test;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic rs, wr_n, rd_n, serial_select_n, busy, gt_o, dir_o, fol, don, con, cbl, gcs, pwr, bw, lc, gs;
    logic [7:0] hdb, odb, oe, bus, v, w;
    logic [6:0] ptr_o, shf;
    logic [1:0] ft;
    logic [1:0] md = 2'h0;
    int n_errors = 0;
    int cmp_count = 0;
    int dd[128];
    int cg[64];
    int ptr = 0;
    int gt = 0;
    int dir = 1;
    int a0;
    always #4 i_sys_clk = ~i_sys_clk;
    assign bus = (odb & oe) | (hdb & ~oe);
    coid_decoder #(.CLEAR_CYCLES(200)) u_coid_decoder (
        .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(1'b1), .i_port_mode(md),
        .i_cmd_data_select(rs), .i_rw_write_strobe(wr_n), .i_enable_read_strobe(rd_n),
        .i_serial_select_n(serial_select_n), .i_db(bus), .o_db(odb), .o_db_oe(oe),
        .o_operation_pending_flag(busy), .o_address_pointer(ptr_o), .o_glyph_target(gt_o),
        .o_display_shift(shf), .o_step_direction(dir_o), .o_display_follow_shift(fol),
        .o_display_on(don), .o_cursor_on(con), .o_cursor_blink(cbl),
        .o_graphic_char_select(gcs), .o_internal_power_on(pwr), .o_bus_width_select(bw),
        .o_line_count_select(lc), .o_glyph_size_select(gs), .o_font_table_select(ft));
    coid_host u_coid_host (.i_clk(i_sys_clk), .i_dbus(bus), .o_rs(rs), .o_wr_n(wr_n),
        .o_rd_n(rd_n), .o_db(hdb), .i_m68(md == 2'h1), .o_csb_n(serial_select_n));
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic ins(input logic [7:0] b);
        u_coid_host.wr(1'b0, b);
        u_coid_host.wait_idle();
    endtask
    task automatic step();
        ptr = dir ? ptr + 1 : ptr - 1;
        ptr = gt ? ptr & 63 : ptr & 127;
    endtask
    task automatic dw(input logic [7:0] b);
        u_coid_host.wr(1'b1, b);
        u_coid_host.wait_idle();
        if (gt) cg[ptr] = b;
        else dd[ptr] = b;
        step();
    endtask
    task automatic dr();
        u_coid_host.rd(1'b1, v);
        u_coid_host.wait_idle();
        chk("data", 8'(gt ? cg[ptr] : dd[ptr]), v);
        step();
    endtask
    task automatic st();
        u_coid_host.rd(1'b0, v);
        chk("status", {1'b0, 7'(ptr)}, v);
    endtask
    initial begin
        #400_000;
        n_errors++;
        final_report();
    end
    initial begin
        void'($urandom(50685));
        repeat (5) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        chk("reset", 8'h03, {6'h00, bw, dir_o});
        ins(8'h01);
        for (int i = 0; i < 128; i++)
            dd[i] = 32'h0000_0020;
        st();
        repeat (3) dr();
        a0 = $urandom_range(120, 0);
        ptr = a0;
        ins(8'h80 | 8'(a0));
        repeat (4) dw(8'($urandom));
        st();
        ptr = a0;
        ins(8'h80 | 8'(a0));
        repeat (4) dr();
        ins(8'h04);
        dir = 0;
        dw(8'h5a);
        st();
        ins(8'h07);
        dir = 1;
        dw(8'ha5);
        chk("follow", 8'h01, {1'b0, shf});
        ins(8'h06);
        ins(8'h1c);
        chk("dshift", 8'h02, {1'b0, shf});
        st();
        ins(8'h14);
        ptr = (ptr + 1) & 127;
        st();
        for (int i = 0; i < 8; i++) begin
            ins(8'h08 | 8'(i));
            chk("disp", 8'(i), {5'h00, don, con, cbl});
        end
        for (int i = 0; i < 4; i++) begin
            ins(8'h13 | 8'(i << 2));
            chk("mode", 8'(i), {6'h00, gcs, pwr});
        end
        for (int i = 0; i < 16; i++) begin
            ins(8'h30 | 8'(i));
            chk("func", 8'(16 + i), {3'h0, bw, lc, gs, ft});
        end
        ins(8'h02);
        ptr = 0;
        chk("home", 8'h00, {1'b0, shf});
        dr();
        gt = 1;
        ptr = 63;
        ins(8'h7f);
        chk("gsel", 8'h01, {7'h00, gt_o});
        dw(8'h3c);
        st();
        ptr = 63;
        ins(8'h7f);
        dr();
        u_coid_host.wr(1'b0, 8'h01);
        u_coid_host.wr(1'b0, 8'h85);
        u_coid_host.wait_idle();
        gt = 0;
        ptr = 0;
        st();
        u_coid_host.wr(1'b0, 8'h20);
        u_coid_host.wr(1'b0, 8'h80);
        u_coid_host.wr(1'b0, 8'h50);
        u_coid_host.rd(1'b0, v);
        u_coid_host.rd(1'b0, w);
        chk("nibble", 8'h05, {v[7:4], w[7:4]});
        i_srst <= 1'b1;
        md <= 2'h1;
        @(posedge i_sys_clk);
        u_coid_host.park();
        repeat (5) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        chk("reset", 8'h03, {6'h00, bw, dir_o});
        st();
        a0 = $urandom;
        dw(8'(a0));
        ins(8'h80);
        ptr = 0;
        dr();
        md <= 2'h2;
        a0 = $urandom;
        u_coid_host.ser({2'b00, 8'h80}, v);
        u_coid_host.ser({2'b10, 8'(a0)}, v);
        u_coid_host.ser({2'b01, 8'h00}, v);
        chk("sstatus", 8'h01, v);
        u_coid_host.ser({2'b00, 8'h80}, v);
        u_coid_host.ser({2'b11, 8'h00}, v);
        chk("sdata", 8'(a0), v);
        final_report();
    end
endmodule
`default_nettype wire
